// *** ccio_params.svh ***
`ifndef CCIO_PARAMS_SVH
`define CCIO_PARAMS_SVH

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define CCIO_ADR_W          8
`define CCIO_REG_CHOOSER    8'h00
`define CCIO_REG_LINECFG    8'h04
`define CCIO_REG_SWLEVEL    8'h08
`define CCIO_REG_GLITCH     8'h0C
`define CCIO_REG_STATUS     8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCIO_CFG_DIR_BIT    0
`define CCIO_CFG_FLIP_BIT   1
`define CCIO_CFG_ORG_LSB    4
`define CCIO_CFG_ORG_MSB    6
`define CCIO_ST_LEVEL_LSB   0
`define CCIO_ST_OE_LSB      2
`define CCIO_ST_DIR_LSB     4

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCIO_CHOOSER_RST    1'h0
`define CCIO_DIR_RST        2'h2
`define CCIO_SWLEVEL_RST    1'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define CCIO_CLK_MHZ        50
`define CCIO_TICK_NS        100
`define CCIO_TICK_CYCLES    ((`CCIO_CLK_MHZ * `CCIO_TICK_NS) / 1000)
`define CCIO_GLITCH_W       24
`define CCIO_GLITCH_MAX_US  1000000
`define CCIO_GLITCH_MAX     24'h989680
`define CCIO_GLITCH_RST     24'h000005

`endif

// *** ccio_pkg.sv ***
package ccio_pkg;

  typedef enum logic [2:0]
  {
    CCIO_ORG_OFF      = 3'h0,
    CCIO_ORG_EXPOSURE = 3'h1,
    CCIO_ORG_READOUT  = 3'h2,
    CCIO_ORG_SWLEVEL  = 3'h3,
    CCIO_ORG_TIMER    = 3'h4,
    CCIO_ORG_STROBE   = 3'h5
  } ccio_origin_t;

  typedef enum logic
  {
    CCIO_FILT_STABLE  = 1'b0,
    CCIO_FILT_QUALIFY = 1'b1
  } ccio_filt_state_t;

  typedef struct packed
  {
    logic         dirOut;
    logic         flip;
    ccio_origin_t origin;
  } ccio_line_cfg_t;

endpackage

// *** ccio_filter_if.sv ***
`timescale 1ns/1ps
`include "ccio_params.svh"

interface ccio_filter_if;
  logic                     tick;
  logic [`CCIO_GLITCH_W-1:0] interval;
  logic                     rawPin;
  logic                     level;

  modport ctrl
  (
    output tick,
    output interval,
    output rawPin,
    input  level
  );

  modport filt
  (
    input  tick,
    input  interval,
    input  rawPin,
    output level
  );
endinterface

// *** ccio_glitch_filter.sv ***
`timescale 1ns/1ps
`include "ccio_params.svh"

module ccio_glitch_filter
  import ccio_pkg::*;
(
  input wire logic    ref_clk,
  input wire logic    rst,
  ccio_filter_if.filt fIf
);

  logic                      sync1Ff;
  logic                      sync2Ff;
  logic                      sync3Ff;
  logic                      levelFf;
  logic                      nxt_level;
  ccio_filt_state_t          stateFf;
  ccio_filt_state_t          nxt_state;
  logic [`CCIO_GLITCH_W-1:0] countFf;
  logic [`CCIO_GLITCH_W-1:0] nxt_count;
  logic                      agree;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1Ff <= 1'b0;
      sync2Ff <= 1'b0;
      sync3Ff <= 1'b0;
    end
    else
    begin
      sync1Ff <= fIf.rawPin;
      sync2Ff <= sync1Ff;
      sync3Ff <= sync2Ff;
    end
  end

  assign agree = (sync2Ff == sync3Ff);

  // ----------------------------------------
  // qualification
  // ----------------------------------------
  always_comb
  begin
    nxt_state = stateFf;
    nxt_level = levelFf;
    nxt_count = countFf;
    case (stateFf)
      CCIO_FILT_STABLE:
      begin
        if (agree && (sync3Ff != levelFf))
        begin
          if (fIf.interval == '0)
            nxt_level = sync3Ff;
          else
          begin
            nxt_state = CCIO_FILT_QUALIFY;
            nxt_count = '0;
          end
        end
      end
      CCIO_FILT_QUALIFY:
      begin
        // short level drops back: rejected
        if (agree && (sync3Ff == levelFf))
          nxt_state = CCIO_FILT_STABLE; // RULE12
        else if (agree && fIf.tick)
        begin
          // first tick is partial, so one tick beyond the interval is waited
          if (countFf >= fIf.interval)
          begin
            nxt_level = sync3Ff; // RULE13
            nxt_state = CCIO_FILT_STABLE;
          end
          else
            nxt_count = countFf + 1'b1;
        end
      end
      default:
        nxt_state = CCIO_FILT_STABLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stateFf <= CCIO_FILT_STABLE;
      levelFf <= 1'b0;
      countFf <= '0;
    end
    else
    begin
      stateFf <= nxt_state;
      levelFf <= nxt_level;
      countFf <= nxt_count;
    end
  end

  assign fIf.level = levelFf;

endmodule

// *** ccio_top.sv ***
// Behaviour
// RULE1: line chooser steers which line gets writes
// RULE2: line a works as filtered input
// RULE3: line b drives chosen output origin
// RULE4: polarity flip inverts line output
// RULE5: origin off releases the line drive
// RULE6: exposure origin follows exposure window
// RULE7: readout origin high during frame readout
// RULE8: software origin follows software level value
// RULE9: timer origin follows timer pulse
// RULE10: strobe origin follows row-span strobe
// RULE11: reject interval zero to 1e6 us, 0.5us; the code steps it in 0.1 us units
// RULE12: levels shorter than interval are ignored
// RULE13: valid edge takes effect after interval
// RULE14: inversion applied after origin selection
// RULE15: off origin rests low before inversion
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "ccio_params.svh"

module ccio_top
  import ccio_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `CCIO_TICK_CYCLES
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [`CCIO_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  pinAIn,
  output logic                       pinAOut,
  output logic                       pinAOe,
  input  wire logic                  pinBIn,
  output logic                       pinBOut,
  output logic                       pinBOe,
  input  wire logic                  exposureWindowPulse,
  input  wire logic                  readoutWindowPulse,
  input  wire logic                  timerPulseOut,
  input  wire logic                  strobePulse,
  output logic                       softwareLevelOut,
  output logic      [1:0]            lineLevel
);

  localparam int unsigned NUM_LINES = 2;
  localparam int unsigned TICK_W    = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // ----------------------------------------
  // register index decode
  // ----------------------------------------
  localparam logic [2:0] IDX_CHOOSER = 3'h0;
  localparam logic [2:0] IDX_LINECFG = 3'h1;
  localparam logic [2:0] IDX_SWLEVEL = 3'h2;
  localparam logic [2:0] IDX_GLITCH  = 3'h3;
  localparam logic [2:0] IDX_STATUS  = 3'h4;
  localparam logic [2:0] IDX_NONE    = 3'h7;

  function automatic logic [2:0] regIndex(input logic [`CCIO_ADR_W-1:0] adr);
    logic [2:0] idx;
    idx = IDX_NONE;
    case (adr)
      `CCIO_REG_CHOOSER: idx = IDX_CHOOSER;
      `CCIO_REG_LINECFG: idx = IDX_LINECFG;
      `CCIO_REG_SWLEVEL: idx = IDX_SWLEVEL;
      `CCIO_REG_GLITCH:  idx = IDX_GLITCH;
      `CCIO_REG_STATUS:  idx = IDX_STATUS;
      default:           idx = IDX_NONE;
    endcase
    return idx;
  endfunction

  // ----------------------------------------
  // origin decode
  // ----------------------------------------
  function automatic logic originLevel
  (
    input ccio_origin_t org,
    input logic         expo,
    input logic         rdo,
    input logic         sw,
    input logic         tmr,
    input logic         stb
  );
    logic lvl;
    lvl = 1'b0;
    case (org)
      CCIO_ORG_OFF:      lvl = 1'b0; // RULE15
      CCIO_ORG_EXPOSURE: lvl = expo; // RULE6
      CCIO_ORG_READOUT:  lvl = rdo;  // RULE7
      CCIO_ORG_SWLEVEL:  lvl = sw;   // RULE8
      CCIO_ORG_TIMER:    lvl = tmr;  // RULE9
      CCIO_ORG_STROBE:   lvl = stb;  // RULE10
      default:           lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // unknown origin codes behave as off
  function automatic logic originDrives(input ccio_origin_t org);
    logic drv;
    drv = 1'b0;
    case (org)
      CCIO_ORG_EXPOSURE,
      CCIO_ORG_READOUT,
      CCIO_ORG_SWLEVEL,
      CCIO_ORG_TIMER,
      CCIO_ORG_STROBE:   drv = 1'b1;
      default:           drv = 1'b0;
    endcase
    return drv;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic                      chooserFf;
  ccio_line_cfg_t            cfgFf [NUM_LINES];
  logic                      swLevelFf;
  logic [`CCIO_GLITCH_W-1:0] glitchFf;
  logic [`CCIO_GLITCH_W-1:0] nxt_glitch;
  logic [TICK_W-1:0]         tickCntFf;
  logic                      tickFf;
  logic                      ackFf;
  logic [31:0]               datFf;
  logic [31:0]               nxt_dat;
  logic                      busReq;
  logic                      busWrite;
  logic [2:0]                busIdx;
  logic [NUM_LINES-1:0]      pinIn;
  logic [NUM_LINES-1:0]      outFf;
  logic [NUM_LINES-1:0]      oeFf;
  logic [NUM_LINES-1:0]      filtLevel;
  logic [NUM_LINES-1:0]      dirVec;

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  // one wait state: ack registered, so read data is a flop too
  assign busReq   = wb_cyc_i && wb_stb_i && !ackFf;
  assign busWrite = busReq && wb_we_i;
  assign busIdx   = regIndex(wb_adr_i);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ackFf <= 1'b0;
    else
      ackFf <= busReq;
  end

  always_comb
  begin
    nxt_dat = 32'h00000000;
    case (busIdx)
      IDX_CHOOSER:
        nxt_dat[0] = chooserFf;
      IDX_LINECFG:
      begin
        nxt_dat[`CCIO_CFG_DIR_BIT]  = cfgFf[chooserFf].dirOut;
        nxt_dat[`CCIO_CFG_FLIP_BIT] = cfgFf[chooserFf].flip;
        nxt_dat[`CCIO_CFG_ORG_MSB:`CCIO_CFG_ORG_LSB] = cfgFf[chooserFf].origin;
      end
      IDX_SWLEVEL:
        nxt_dat[0] = swLevelFf;
      IDX_GLITCH:
        nxt_dat[`CCIO_GLITCH_W-1:0] = glitchFf;
      IDX_STATUS:
      begin
        nxt_dat[`CCIO_ST_LEVEL_LSB +: NUM_LINES] = lineLevel;
        nxt_dat[`CCIO_ST_OE_LSB +: NUM_LINES]    = oeFf;
        nxt_dat[`CCIO_ST_DIR_LSB +: NUM_LINES]   = dirVec;
      end
      default:
        nxt_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      datFf <= 32'h00000000;
    else if (busReq && !wb_we_i)
      datFf <= nxt_dat;
  end

  assign wb_ack_o = ackFf;
  assign wb_dat_o = datFf;

  // ----------------------------------------
  // line chooser
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      chooserFf <= `CCIO_CHOOSER_RST;
    else if (busWrite && busIdx == IDX_CHOOSER && wb_sel_i[0])
      chooserFf <= wb_dat_i[0];
  end

  // ----------------------------------------
  // per-line configuration
  // ----------------------------------------
  // only the chosen line's slot is written; the other keeps its setup
  genvar c;
  generate
    for (c = 0; c < NUM_LINES; c++)
    begin : gCfg
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          cfgFf[c].dirOut <= 1'(`CCIO_DIR_RST >> c);
          cfgFf[c].flip   <= 1'b0;
          cfgFf[c].origin <= CCIO_ORG_OFF;
        end
        else if (busWrite && busIdx == IDX_LINECFG && wb_sel_i[0]
                 && chooserFf == 1'(c)) // RULE1
        begin
          cfgFf[c].dirOut <= wb_dat_i[`CCIO_CFG_DIR_BIT];
          cfgFf[c].flip   <= wb_dat_i[`CCIO_CFG_FLIP_BIT];
          cfgFf[c].origin <= ccio_origin_t'(wb_dat_i[`CCIO_CFG_ORG_MSB:`CCIO_CFG_ORG_LSB]);
        end
      end
      assign dirVec[c] = cfgFf[c].dirOut;
    end
  endgenerate

  // ----------------------------------------
  // software level
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      swLevelFf <= `CCIO_SWLEVEL_RST;
    else if (busWrite && busIdx == IDX_SWLEVEL && wb_sel_i[0])
      swLevelFf <= wb_dat_i[0];
  end

  assign softwareLevelOut = swLevelFf;

  // ----------------------------------------
  // reject interval, 0.1 us units
  // ----------------------------------------
  // byte lanes merge first, then the clamp keeps the 1e6 us ceiling
  always_comb
  begin
    nxt_glitch = glitchFf;
    if (wb_sel_i[0])
      nxt_glitch[7:0] = wb_dat_i[7:0];
    if (wb_sel_i[1])
      nxt_glitch[15:8] = wb_dat_i[15:8];
    if (wb_sel_i[2])
      nxt_glitch[23:16] = wb_dat_i[23:16];
    if (nxt_glitch > `CCIO_GLITCH_MAX)
      nxt_glitch = `CCIO_GLITCH_MAX; // RULE11
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      glitchFf <= `CCIO_GLITCH_RST; // RULE11
    else if (busWrite && busIdx == IDX_GLITCH)
      glitchFf <= nxt_glitch;
  end

  // ----------------------------------------
  // 100 ns tick divider
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tickCntFf <= '0;
      tickFf    <= 1'b0;
    end
    else if (tickCntFf == TICK_LAST)
    begin
      tickCntFf <= '0;
      tickFf    <= 1'b1;
    end
    else
    begin
      tickCntFf <= tickCntFf + 1'b1;
      tickFf    <= 1'b0;
    end
  end

  // ----------------------------------------
  // input filters
  // ----------------------------------------
  assign pinIn = {pinBIn, pinAIn};

  genvar f;
  generate
    for (f = 0; f < NUM_LINES; f++)
    begin : gFilt
      ccio_filter_if fIf ();

      assign fIf.tick     = tickFf;
      assign fIf.interval = glitchFf;
      assign fIf.rawPin   = pinIn[f];
      assign filtLevel[f] = fIf.level;

      ccio_glitch_filter uFilt
      (
        .ref_clk (ref_clk),
        .rst     (rst),
        .fIf     (fIf.filt)
      );
    end
  endgenerate

  // ----------------------------------------
  // output drivers
  // ----------------------------------------
  // flip sits after the origin mux, so software level inverts as well
  genvar o;
  generate
    for (o = 0; o < NUM_LINES; o++)
    begin : gOut
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          outFf[o] <= 1'b0;
        else
          outFf[o] <= originLevel(cfgFf[o].origin, exposureWindowPulse,
                                  readoutWindowPulse, swLevelFf, timerPulseOut,
                                  strobePulse) ^ cfgFf[o].flip; // RULE4 RULE14
      end

      always_ff @(posedge ref_clk)
      begin
        if (rst)
          oeFf[o] <= 1'b0;
        else
          oeFf[o] <= cfgFf[o].dirOut && originDrives(cfgFf[o].origin); // RULE3 RULE5
      end

      // input lines report the filtered level, output lines their drive
      assign lineLevel[o] = cfgFf[o].dirOut ? outFf[o] : filtLevel[o]; // RULE2
    end
  endgenerate

  assign pinAOut = outFf[0];
  assign pinAOe  = oeFf[0];
  assign pinBOut = outFf[1];
  assign pinBOe  = oeFf[1];

endmodule

// *** ccio_top_props.sv ***
`timescale 1ns/1ps
`include "ccio_params.svh"

module ccio_top_props
  import ccio_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 5
)
(
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [`CCIO_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic                   pinAIn,
  input wire logic                   pinAOut,
  input wire logic                   pinAOe,
  input wire logic                   pinBIn,
  input wire logic                   pinBOut,
  input wire logic                   pinBOe,
  input wire logic                   exposureWindowPulse,
  input wire logic                   readoutWindowPulse,
  input wire logic                   timerPulseOut,
  input wire logic                   strobePulse,
  input wire logic                   softwareLevelOut,
  input wire logic [1:0]             lineLevel
);
  // ----------------------------------------
  // line b config, snooped off the bus
  // ----------------------------------------
  logic       chooser_ff;
  logic       dirB_ff;
  logic       flipB_ff;
  logic [2:0] orgB_ff;
  wire  logic wrTake = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      chooser_ff <= 1'h0;
    else if (wrTake && wb_adr_i == `CCIO_REG_CHOOSER)
      chooser_ff <= wb_dat_i[0];
  end

  // only line b is tracked; line a is judged by the bench
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      {dirB_ff, flipB_ff, orgB_ff} <= 5'h10;
    else if (wrTake && wb_adr_i == `CCIO_REG_LINECFG && chooser_ff)
      {dirB_ff, flipB_ff, orgB_ff} <= {wb_dat_i[0], wb_dat_i[1], wb_dat_i[6:4]};
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !wb_ack_o && !pinAOe && !pinBOe && !softwareLevelOut) else $error("output active after reset");
  chk_ack_once: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
  chk_b_drive_enable: assert property (
    pinBOe == ($past(dirB_ff) && $past(orgB_ff) != 3'h0 && $past(orgB_ff) < 3'h6)) else $error("line b enable wrong");
  chk_b_off_rest: assert property (
    $past(orgB_ff) == CCIO_ORG_OFF |-> pinBOut == $past(flipB_ff)) else $error("off level wrong");
  chk_b_exposure: assert property (
    $past(orgB_ff) == CCIO_ORG_EXPOSURE |-> pinBOut == ($past(exposureWindowPulse) ^ $past(flipB_ff)))
    else $error("exposure output wrong");
  chk_b_readout: assert property (
    $past(orgB_ff) == CCIO_ORG_READOUT |-> pinBOut == ($past(readoutWindowPulse) ^ $past(flipB_ff)))
    else $error("readout output wrong");
  chk_b_software: assert property (
    $past(orgB_ff) == CCIO_ORG_SWLEVEL |-> pinBOut == ($past(softwareLevelOut) ^ $past(flipB_ff)))
    else $error("software output wrong");
  chk_b_timer: assert property (
    $past(orgB_ff) == CCIO_ORG_TIMER |-> pinBOut == ($past(timerPulseOut) ^ $past(flipB_ff)))
    else $error("timer output wrong");
  chk_b_strobe: assert property (
    $past(orgB_ff) == CCIO_ORG_STROBE |-> pinBOut == ($past(strobePulse) ^ $past(flipB_ff)))
    else $error("strobe output wrong");
endmodule

bind ccio_top ccio_top_props #(.TICK_CYCLES(TICK_CYCLES)) uProps
(
  .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pinAIn(pinAIn), .pinAOut(pinAOut), .pinAOe(pinAOe), .pinBIn(pinBIn),
  .pinBOut(pinBOut), .pinBOe(pinBOe), .exposureWindowPulse(exposureWindowPulse),
  .readoutWindowPulse(readoutWindowPulse), .timerPulseOut(timerPulseOut),
  .strobePulse(strobePulse), .softwareLevelOut(softwareLevelOut), .lineLevel(lineLevel)
);

// *** ccio_ext_equip.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// trigger source on line a
// ----------------------------------------
module ccio_ext_equip
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       fire,
  input wire logic [7:0] highLen,
  output logic           lineDrive
);
  logic [7:0] left_ff;

  // pulse is exactly highLen cycles wide for highLen of 1 or more (0 gives 1 cycle), so glitch lengths are exact
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      left_ff   <= 8'h00;
      lineDrive <= 1'b0;
    end
    else if (fire)
    begin
      left_ff   <= highLen;
      lineDrive <= 1'b1;
    end
    else if (left_ff > 8'h01)
      left_ff <= left_ff - 8'h01;
    else
      lineDrive <= 1'b0;
  end
endmodule

// *** tb_camera_control_io_lines.sv ***
`timescale 1ns/1ps
`include "ccio_params.svh"

module tb_camera_control_io_lines;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [7:0]  wbAdr = 8'h00;
  logic [31:0] wbDat = 32'h0, wbDatO;
  logic        pinAOut, pinAOe, pinBOut, pinBOe, swOut, lineDrive;
  logic        expo = 1'b0, rdo = 1'b0, tmr = 1'b0, strb = 1'b0, fire = 1'b0;
  logic [7:0]  fireLen = 8'h00;
  logic [1:0]  lineLevel;
  int          error_cnt = 0, checked = 0, cycles = 0;

  // ----------------------------------------
  // wiring and clock
  // ----------------------------------------
  // line b released: pull-down level
  wire logic pinAIn = pinAOe ? pinAOut : lineDrive;
  wire logic pinBIn = pinBOe ? pinBOut : 1'b0;

  always #10 ref_clk = ~ref_clk;

  ccio_top #(.TICK_CYCLES(5)) DUT
  (
    .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .pinAIn(pinAIn), .pinAOut(pinAOut), .pinAOe(pinAOe), .pinBIn(pinBIn), .pinBOut(pinBOut),
    .pinBOe(pinBOe), .exposureWindowPulse(expo), .readoutWindowPulse(rdo),
    .timerPulseOut(tmr), .strobePulse(strb), .softwareLevelOut(swOut), .lineLevel(lineLevel)
  );

  ccio_ext_equip uEquip
  (
    .ref_clk(ref_clk), .rst(rst), .fire(fire), .highLen(fireLen), .lineDrive(lineDrive)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      $display("[ERR] timeout expected 0 seen 1");
      results();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  // no fixed latency assumed: wait for ack at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= w;
    wbAdr <= a;
    wbDat <= d;
    @(posedge ref_clk);
    while (wbAck !== 1'b1)
      @(posedge ref_clk);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_defaults();
    rdChk("cfg a", `CCIO_REG_LINECFG, 32'h0);
    wr(`CCIO_REG_CHOOSER, 32'h1);
    rdChk("cfg b", `CCIO_REG_LINECFG, 32'h1);
    rdChk("glitch rst", `CCIO_REG_GLITCH, 32'h5);
    rdChk("unmapped", 8'h20, 32'h0);
    wr(`CCIO_REG_GLITCH, 32'hFFFFFF);
    rdChk("glitch max", `CCIO_REG_GLITCH, 32'h989680);
    wr(`CCIO_REG_GLITCH, 32'h0);
    rdChk("glitch zero", `CCIO_REG_GLITCH, 32'h0);
  endtask

  // the chosen source gets v, all others get its inverse
  task automatic s_origins();
    logic v, f;
    for (int o = 0; o < 6; o++)
      for (int k = 0; k < 4; k++)
      begin
        v = k[0];
        f = k[1];
        wr(`CCIO_REG_SWLEVEL, {31'h0, (o == 3) ? v : !v});
        wr(`CCIO_REG_LINECFG, {25'h0, o[2:0], 2'h0, f, 1'b1});
        expo <= (o == 1) ? v : !v;
        rdo  <= (o == 2) ? v : !v;
        tmr  <= (o == 4) ? v : !v;
        strb <= (o == 5) ? v : !v;
        repeat (3) @(posedge ref_clk);
        chk("pinBOut", {31'h0, ((o == 0) ? 1'b0 : v) ^ f}, {31'h0, pinBOut});
        chk("pinBOe", {31'h0, o != 0}, {31'h0, pinBOe});
      end
    wr(`CCIO_REG_LINECFG, 32'h30);
    repeat (3) @(posedge ref_clk);
    chk("pinBOe in", 32'h0, {31'h0, pinBOe});
  endtask

  task automatic s_chooser();
    wr(`CCIO_REG_CHOOSER, 32'h0);
    wr(`CCIO_REG_LINECFG, 32'h31);
    wr(`CCIO_REG_SWLEVEL, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk("pinAOe", 32'h1, {31'h0, pinAOe});
    chk("pinAOut", 32'h1, {31'h0, pinAOut});
    chk("pinBOe", 32'h0, {31'h0, pinBOe});
    rdChk("status", `CCIO_REG_STATUS, 32'h15);
    wr(`CCIO_REG_LINECFG, 32'h0);
  endtask

  // one tick of 5 cycles: 4-cycle pulses die at every phase, long pulse passes late
  task automatic s_filter();
    int n;
    int seen;
    wr(`CCIO_REG_GLITCH, 32'h1);
    repeat (20) @(posedge ref_clk);
    seen = 0;
    // an 11-cycle period walks the pulse across all five tick phases
    repeat (5)
    begin
      fireLen <= 8'h04;
      fire    <= 1'b1;
      @(posedge ref_clk);
      fire <= 1'b0;
      repeat (10)
      begin
        @(posedge ref_clk);
        if (lineLevel[0] !== 1'b0)
          seen = 1;
      end
    end
    chk("glitch passed", 32'h0, seen);
    fireLen <= 8'h64;
    fire    <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    n = 1;
    while (lineLevel[0] !== 1'b1 && n < 60)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("delay in window", 32'h1, {31'h0, n >= 10 && n <= 17});
  endtask

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    s_defaults();
    s_origins();
    s_chooser();
    s_filter();
    results();
  end
endmodule
